// ===== rtl/iar_pkg.sv
package iar_pkg;

	// Register byte addresses on the bus.
	localparam logic [4:0] ADDR_SHIFT = 5'h00;
	localparam logic [4:0] ADDR_CTRL = 5'h04;
	localparam logic [4:0] ADDR_STAT = 5'h08;
	localparam logic [4:0] ADDR_FLAG = 5'h0c;
	localparam logic [4:0] ADDR_LSA = 5'h10;
	localparam logic [4:0] ADDR_CSEL = 5'h14;

	// Control register bit positions; strobes are not stored.
	localparam int CTL_LREL = 1;
	localparam int CTL_WREL = 2;
	localparam int CTL_WTIM = 3;
	localparam int CTL_SPIE = 4;
	localparam int CTL_ACKE = 5;
	localparam int CTL_STT = 6;
	localparam int CTL_SPT = 7;
	localparam logic [7:0] CTL_KEEP_MASK = 8'h38;

	// Status register bit positions.
	localparam int ST_MSTS = 7;
	localparam int ST_ALD = 6;
	localparam int ST_EXC = 5;
	localparam int ST_COI = 4;
	localparam int ST_TRC = 3;
	localparam int ST_ACKD = 2;
	localparam int ST_STD = 1;
	localparam int ST_SPD = 0;

	// Flag register bit positions.
	localparam int FL_STCF = 7;
	localparam int FL_BSY = 6;
	localparam int FL_TXERR = 5;
	localparam int FL_EXT_LSB = 1;
	localparam int FL_RSV = 0;

	// Upper address nibbles that mark an extension code.
	localparam logic [3:0] EXT_NIB_LO = 4'h0;
	localparam logic [3:0] EXT_NIB_HI = 4'hf;

	// Size code of a whole-word bus transfer.
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// Master sequencer states.
	typedef enum logic [2:0] {
		M_IDLE, M_START, M_LOW, M_HIGH, M_STOP1, M_STOP2, M_RS1
	} iar_mst_e;

	// Kinds of extension code.
	typedef enum logic [2:0] {
		EXT_NONE, EXT_GCALL, EXT_SBYTE, EXT_LEGACY, EXT_RSVD, EXT_TENBIT,
		EXT_OTHER
	} iar_ext_e;

	// Divider of the peripheral clock picked by the clock select field.
	function automatic logic [11:0] iar_div_sel(input logic [1:0] sel);
		unique case (sel)
			2'h2: iar_div_sel = 12'h001;
			2'h3: iar_div_sel = 12'h003;
			default: iar_div_sel = 12'h002;
		endcase
	endfunction

	// Sorts an address byte with an extension nibble into its kind.
	function automatic iar_ext_e iar_ext_class(input logic [7:0] a);
		if (a[7:1] == 7'h00)
			iar_ext_class = a[0] ? EXT_SBYTE : EXT_GCALL;
		else if (a[7:1] == 7'h01)
			iar_ext_class = EXT_LEGACY;
		else if (a[7:1] == 7'h02)
			iar_ext_class = EXT_RSVD;
		else if (a[7:3] == 5'h1e)
			iar_ext_class = EXT_TENBIT;
		else
			iar_ext_class = EXT_OTHER;
	endfunction

endpackage

// ===== rtl/iar_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser for the bus pins; only the second stage leaves.
module iar_sync #(
	parameter int W = 2
) (
	input logic mclk,
	input logic rst_n,
	input logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	// Both stages live in one state word.
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} iar_sync_s;

	iar_sync_s r, n;

	// The first stage feeds only the second stage.
	always_comb begin
		n.meta = async_in;
		n.stable = r.meta;
	end

	// Pins idle high, so reset to the released level.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			r <= '1;
		else
			r <= n;
	end

	assign sync_out = r.stable;
endmodule

// ===== rtl/iar_top.sv
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
// Function
// - Stop condition raises interrupt if enabled.
// - Hardware compares received address with local address.
// - Shift register captures line; mismatch flags error.
// - Extension nibble sets flag, interrupts at eighth.
// - Ten-bit prefix sets extension and match flags.
// - Extension keeps communication until release bit.
// - Classify extension codes into their kinds.
// - Simultaneous masters stay clock synchronised.
// - Arbitration loss sets flag, releases both lines.
// - Loss interrupts at end of the byte.
// - Loss by stop interrupts only if enabled.
// - Slave stays silent on address mismatch.
// - Start enters wakeup standby through address.
// - Stop interrupt depends only on enable bit.
// - Reserved start issued automatically after stop.
// - Shift writes ignored while reservation pending.
// - Start now if bus free, else reserve.
// - Reservation accepted between start and stop.
// - Reservation disabled: busy start rejected, flagged.
// - Interrupts other than stop, and waits, follow falling clock edge.
module iar_top
	import iar_pkg::*;
#(
	parameter logic [11:0] HALF_CYC = 12'd50
) (
	input logic mclk,
	input logic rst_n,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input logic bus_clock_line_in,
	output logic bus_clock_line_out,
	output logic bus_clock_line_oe,
	input logic bus_data_line_in,
	output logic bus_data_line_out,
	output logic bus_data_line_oe,
	output logic bus_irq
);

	////////////////////////////////////////////////////////////////////////
	// State word.

	// Every flip-flop of the block outside the pin synchroniser sits in this one record.
	typedef struct packed {
		iar_mst_e st; // Master sequencer state.
		logic [11:0] div; // Half-period timer.
		logic [3:0] cnt; // Serial clock pulses seen in this byte.
		logic [7:0] shift; // Shift data register.
		logic [7:0] txd; // Byte as written, kept for read-back.
		logic [7:0] ctl; // Stored control bits.
		logic [7:0] lsa; // Local slave address.
		logic [1:0] csel; // Clock select field.
		logic scl_p; // Clock line one cycle ago.
		logic sda_p; // Data line one cycle ago.
		logic busy; // Bus seen between start and stop.
		logic std; // Start detected.
		logic spd; // Stop detected.
		logic master; // Acting as master.
		logic comm; // Taking part in the transfer.
		logic trc; // Transmitting.
		logic addr_ph; // Address byte in progress.
		logic exc; // Extension code flag.
		logic coi; // Address match flag.
		logic ald; // Arbitration loss flag.
		logic ald_pend; // Loss waiting for its byte-end interrupt.
		logic ackd; // Acknowledge seen.
		logic wt; // Wait: clock line held low.
		logic pend; // Start reservation pending.
		logic stcf; // Start request rejected.
		logic rsv_dis; // Reservation disabled.
		logic txerr; // Read-back mismatch seen.
		logic irq; // Interrupt pulse.
		logic scl_oe; // Clock line pulled low by the sequencer.
		logic sda_oe; // Data line pulled low.
		logic a_val; // Bus data phase pending.
		logic a_wr; // Pending phase is a write.
		logic [4:0] a_addr; // Pending phase address.
		iar_ext_e ext; // Kind of the last extension code.
		logic [31:0] rdata; // Read data of the current phase.
	} iar_st_s;

	iar_st_s r, n;
	logic [1:0] line_s; // Synchronised clock and data lines.
	logic scl_s, sda_s; // Their two halves.
	logic sta, stp, rise, fall; // Line events seen this cycle.
	logic [11:0] hp; // Half period in clock cycles.
	logic tdone; // Half period elapsed.
	logic wr, wr_ctl, wr_shift, lose, match, ext_hit;
	logic [7:0] rd, st_b, fl_b; // Read byte and its assembled sources.

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and edge detection.

	// Both lines cross from the pins through two flops first.
	iar_sync #(.W(2)) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.async_in({bus_clock_line_in, bus_data_line_in}),
		.sync_out(line_s)
	);

	assign scl_s = line_s[1];
	assign sda_s = line_s[0];
	// Start and stop are data edges while the clock is high.
	assign sta = scl_s && r.scl_p && r.sda_p && !sda_s;
	assign stp = scl_s && r.scl_p && !r.sda_p && sda_s;
	assign rise = scl_s && !r.scl_p;
	assign fall = !scl_s && r.scl_p;
	assign hp = HALF_CYC * iar_div_sel(r.csel);
	assign tdone = (r.div >= hp - 12'd1);
	assign wr = r.a_val && r.a_wr;
	assign wr_ctl = wr && (r.a_addr == ADDR_CTRL);
	assign wr_shift = wr && (r.a_addr == ADDR_SHIFT);
	assign match = (r.shift[7:1] == r.lsa[7:1]);
	assign ext_hit = (r.shift[7:4] == EXT_NIB_LO) ||
		(r.shift[7:4] == EXT_NIB_HI);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Order matters: sequencer, then line events, then software, then
	// arbitration loss, so that software writes override line-event sets and a loss overrides all.
	always_comb begin
		n = r;
		n.irq = 1'b0;
		n.scl_p = scl_s;
		n.sda_p = sda_s;
		n.div = tdone ? r.div : r.div + 12'd1;
		lose = 1'b0;

		// Read sources are assembled from the live state.
		st_b = 8'h00;
		st_b[ST_MSTS] = r.master;
		st_b[ST_ALD] = r.ald;
		st_b[ST_EXC] = r.exc;
		st_b[ST_COI] = r.coi;
		st_b[ST_TRC] = r.trc;
		st_b[ST_ACKD] = r.ackd;
		st_b[ST_STD] = r.std;
		st_b[ST_SPD] = r.spd;
		fl_b = 8'h00;
		fl_b[FL_STCF] = r.stcf;
		fl_b[FL_BSY] = r.busy;
		fl_b[FL_TXERR] = r.txerr;
		fl_b[FL_EXT_LSB +: 3] = r.ext;
		fl_b[FL_RSV] = r.rsv_dis;

		// Address phase: capture, and latch read data at once so the
		// data phase needs no wait state. Unmapped addresses read zero.
		n.a_val = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
		unique case (haddr[4:0])
			ADDR_SHIFT: rd = r.shift;
			ADDR_CTRL: rd = r.ctl;
			ADDR_STAT: rd = st_b;
			ADDR_FLAG: rd = fl_b;
			ADDR_LSA: rd = r.lsa;
			ADDR_CSEL: rd = {6'h00, r.csel};
			default: rd = 8'h00;
		endcase
		if (n.a_val) begin
			n.a_wr = hwrite;
			n.a_addr = haddr[4:0];
			if (!hwrite) begin
				n.rdata = {24'h000000, rd};
				// Reading status acknowledges the loss flag.
				if (haddr[4:0] == ADDR_STAT)
					n.ald = 1'b0;
			end
		end

		// Master sequencer drives the clock and start/stop shapes.
		unique case (r.st)
			M_IDLE: n.div = 12'h000;
			M_START: begin
				n.master = 1'b1;
				n.sda_oe = 1'b1;
				// Data already low before we pull it: someone else won.
				if (!r.sda_oe && !sda_s)
					lose = 1'b1;
				if (!scl_s)
					n.div = 12'h000;
				else if (tdone) begin
					n.scl_oe = 1'b1;
					n.wt = 1'b1;
					n.st = M_LOW;
					n.div = 12'h000;
				end
			end
			M_LOW: begin
				n.scl_oe = 1'b1;
				if (tdone && !r.wt) begin
					n.scl_oe = 1'b0;
					n.st = M_HIGH;
					n.div = 12'h000;
				end
			end
			M_HIGH: begin
				// High time counts only while the line is really high;
				// another master pulling low ends it early.
				if (fall) begin
					n.scl_oe = 1'b1;
					n.st = M_LOW;
					n.div = 12'h000;
				end else if (!scl_s)
					n.div = 12'h000;
				else if (tdone) begin
					n.scl_oe = 1'b1;
					n.st = M_LOW;
					n.div = 12'h000;
				end
			end
			M_STOP1: begin
				n.scl_oe = 1'b1;
				n.sda_oe = 1'b1;
				if (tdone) begin
					n.scl_oe = 1'b0;
					n.st = M_STOP2;
					n.div = 12'h000;
				end
			end
			M_STOP2: begin
				if (!scl_s)
					n.div = 12'h000;
				else if (tdone)
					n.sda_oe = 1'b0;
			end
			M_RS1: begin
				n.scl_oe = 1'b1;
				n.sda_oe = 1'b0;
				if (tdone) begin
					n.scl_oe = 1'b0;
					n.st = M_START;
					n.div = 12'h000;
				end
			end
			default: n.st = M_IDLE;
		endcase

		// Start condition: wakeup standby until the address is judged.
		if (sta) begin
			n.std = 1'b1;
			n.spd = 1'b0;
			n.busy = 1'b1;
			n.cnt = 4'h0;
			n.addr_ph = 1'b1;
			n.comm = r.master;
			n.trc = r.master;
			n.exc = 1'b0;
			n.coi = 1'b0;
			n.ald_pend = 1'b0;
			n.ext = EXT_NONE;
		end

		// Stop condition: the enable alone decides the interrupt.
		if (stp) begin
			n.spd = 1'b1;
			n.std = 1'b0;
			n.busy = 1'b0;
			n.comm = 1'b0;
			n.master = 1'b0;
			n.addr_ph = 1'b0;
			n.wt = 1'b0;
			n.trc = 1'b0;
			n.scl_oe = 1'b0;
			n.sda_oe = 1'b0;
			n.st = M_IDLE;
			n.irq = r.ctl[CTL_SPIE];
			if (r.pend) begin
				n.pend = 1'b0;
				n.st = M_START;
				n.master = 1'b1;
				n.div = 12'h000;
			end
		end

		// Rising clock: the line level goes into the shift register, on the ninth pulse into the acknowledge flag.
		if (rise) begin
			if (r.cnt < 4'd8)
				n.shift = {r.shift[6:0], sda_s};
			else
				n.ackd = !sda_s;
			n.cnt = r.cnt + 4'd1;
			// Released a one but read a zero: arbitration lost.
			if (r.master && r.trc && r.cnt < 4'd8 && !r.sda_oe && !sda_s)
				lose = 1'b1;
		end

		// Falling clock: interrupts and waits are tied to this edge.
		if (fall) begin
			if (r.cnt == 4'd8) begin
				n.sda_oe = 1'b0;
				if (r.addr_ph && ext_hit) begin
					n.exc = 1'b1;
					n.coi = match;
					n.ext = iar_ext_class(r.shift);
					n.comm = 1'b1;
					n.irq = 1'b1;
					n.wt = 1'b1;
					n.sda_oe = !r.master && r.ctl[CTL_ACKE];
					if (r.ald_pend && !r.ctl[CTL_WTIM])
						n.ald_pend = 1'b0;
				end else if (r.addr_ph)
					n.sda_oe = !r.master && match;
				else if (r.comm) begin
					n.sda_oe = !r.trc && r.ctl[CTL_ACKE];
					if (!r.ctl[CTL_WTIM]) begin
						n.irq = 1'b1;
						n.wt = 1'b1;
					end
				end
			end else if (r.cnt == 4'd9) begin
				n.cnt = 4'h0;
				n.sda_oe = 1'b0;
				if (r.comm && r.trc && r.shift != r.txd)
					n.txerr = 1'b1;
				if (r.addr_ph) begin
					n.addr_ph = 1'b0;
					if (!r.exc) begin
						if (r.master) begin
							n.irq = 1'b1;
							n.wt = 1'b1;
							n.trc = !r.shift[0];
						end else if (match) begin
							n.coi = 1'b1;
							n.comm = 1'b1;
							n.trc = r.shift[0];
							n.irq = 1'b1;
							n.wt = 1'b1;
						end else
							n.comm = 1'b0;
					end
				end else if (r.comm && r.ctl[CTL_WTIM]) begin
					n.irq = 1'b1;
					n.wt = 1'b1;
				end
				if (r.ald_pend) begin
					n.irq = 1'b1;
					n.ald_pend = 1'b0;
				end
			end else if (r.cnt != 4'd0 && r.comm && r.trc)
				n.sda_oe = !r.txd[3'(4'd7 - r.cnt)];
		end

		// Control writes; the strobe bits act and are not stored.
		if (wr_ctl) begin
			n.ctl = hwdata[7:0] & CTL_KEEP_MASK;
			if (hwdata[CTL_LREL] && !r.master) begin
				n.comm = 1'b0;
				n.wt = 1'b0;
				n.addr_ph = 1'b0;
				n.trc = 1'b0;
				n.exc = 1'b0;
				n.coi = 1'b0;
				n.sda_oe = 1'b0;
				n.pend = 1'b0;
			end
			if (hwdata[CTL_WREL])
				n.wt = 1'b0;
			if (hwdata[CTL_STT]) begin
				if (r.master && r.wt) begin
					n.wt = 1'b0;
					n.st = M_RS1;
					n.div = 12'h000;
				end else if (!r.busy) begin
					n.st = M_START;
					n.div = 12'h000;
					n.stcf = 1'b0;
				end else if (!r.comm && !r.master) begin
					// Busy but not ours: reserve, or refuse if disabled.
					if (r.rsv_dis)
						n.stcf = 1'b1;
					else
						n.pend = 1'b1;
				end
			end
			if (hwdata[CTL_SPT] && r.master && r.wt) begin
				n.wt = 1'b0;
				n.st = M_STOP1;
				n.div = 12'h000;
			end
		end
		if (wr && r.a_addr == ADDR_LSA)
			n.lsa = hwdata[7:0];
		if (wr && r.a_addr == ADDR_CSEL)
			n.csel = hwdata[1:0];
		if (wr && r.a_addr == ADDR_FLAG)
			n.rsv_dis = hwdata[FL_RSV];
		// Before the bus frees, a reserved master must not send.
		if (wr_shift && !r.pend) begin
			n.shift = hwdata[7:0];
			n.txd = hwdata[7:0];
			n.wt = 1'b0;
			if (n.trc && r.cnt == 4'd0)
				n.sda_oe = !hwdata[7];
		end

		// Arbitration loss frees both lines and drops any reservation.
		if (lose) begin
			n.ald = 1'b1;
			n.ald_pend = 1'b1;
			n.master = 1'b0;
			n.trc = 1'b0;
			n.comm = 1'b0;
			n.wt = 1'b0;
			n.scl_oe = 1'b0;
			n.sda_oe = 1'b0;
			n.st = M_IDLE;
			n.pend = 1'b0;
		end
	end

	// All state resets to zero: idle, no flags, lines released.
	// The line history starts at the idle high level instead.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			// A zero history would read as a clock rise after reset and
			// shift a stray bit into the shift register.
			r <= '0;
			r.scl_p <= 1'b1;
			r.sda_p <= 1'b1;
		end else
			r <= n;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.

	// Open-drain lines: only the enables move, the level stays low.
	assign bus_clock_line_out = 1'b0;
	assign bus_clock_line_oe = r.scl_oe | r.wt;
	assign bus_data_line_out = 1'b0;
	assign bus_data_line_oe = r.sda_oe;
	assign bus_irq = r.irq;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r.rdata;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	property p_stop_irq;
		@(posedge mclk) disable iff (!rst_n)
		stp && r.ctl[CTL_SPIE] |=> bus_irq;
	endproperty
	a_stop_irq: assert property (p_stop_irq)
		else $error("stop seen with enable but no interrupt");

	property p_stop_quiet;
		@(posedge mclk) disable iff (!rst_n)
		stp && !r.ctl[CTL_SPIE] |=> !bus_irq;
	endproperty
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("stop interrupt without enable");

	property p_ext;
		@(posedge mclk) disable iff (!rst_n)
		fall && r.cnt == 4'd8 && r.addr_ph && r.shift[7:4] == 4'h0
		|=> r.exc && bus_irq && r.comm;
	endproperty
	a_ext: assert property (p_ext)
		else $error("extension code missed at eighth edge");

	property p_tenbit;
		@(posedge mclk) disable iff (!rst_n)
		fall && r.cnt == 4'd8 && r.addr_ph && r.shift[7:3] == 5'h1e &&
		r.shift[7:1] == r.lsa[7:1] |=> r.exc && r.coi;
	endproperty
	a_tenbit: assert property (p_tenbit)
		else $error("ten-bit prefix match not flagged");

	property p_nomatch;
		@(posedge mclk) disable iff (!rst_n)
		fall && r.cnt == 4'd9 && r.addr_ph && !r.master && !r.exc &&
		!r.ald_pend && r.shift[7:1] != r.lsa[7:1]
		|=> !bus_irq && !r.comm ##1 !bus_irq;
	endproperty
	a_nomatch: assert property (p_nomatch)
		else $error("interrupt on address mismatch");

	property p_arb;
		@(posedge mclk) disable iff (!rst_n)
		rise && r.master && r.trc && r.cnt < 4'd8 && !r.sda_oe && !sda_s
		|=> r.ald && !r.master && !bus_data_line_oe && !bus_clock_line_oe;
	endproperty
	a_arb: assert property (p_arb)
		else $error("arbitration loss did not release the bus");

	property p_pend_go;
		@(posedge mclk) disable iff (!rst_n)
		r.pend && stp && !wr_ctl |=> !r.pend && r.st == M_START
		##1 bus_data_line_oe;
	endproperty
	a_pend_go: assert property (p_pend_go)
		else $error("reserved start not issued after stop");

	property p_rsv_ign;
		@(posedge mclk) disable iff (!rst_n)
		wr_shift && r.pend && !rise |=> r.shift == $past(r.shift);
	endproperty
	a_rsv_ign: assert property (p_rsv_ign)
		else $error("shift write taken during reservation");

	property p_reject;
		@(posedge mclk) disable iff (!rst_n)
		wr_ctl && hwdata[CTL_STT] && r.busy && !r.comm && !r.master &&
		r.rsv_dis && !stp && !lose |=> r.stcf && !r.pend && r.st == M_IDLE;
	endproperty
	a_reject: assert property (p_reject)
		else $error("start not rejected with reservation off");

	property p_capture;
		@(posedge mclk) disable iff (!rst_n)
		rise && r.cnt < 4'd8 && !wr_shift |=> r.shift[0] == $past(sda_s);
	endproperty
	a_capture: assert property (p_capture)
		else $error("line level not captured");
endmodule

// ===== bench/iar_far_master.sv
`timescale 1ns/10ps
// Behavioural master on the two-wire bus; it only pulls lines low.
module iar_far_master (
	input wire logic scl,
	input wire logic sda,
	output logic scl_oe,
	output logic sda_oe
);
	// Half of the 200 ns link clock period.
	localparam int HALF = 100;
	// Acknowledge seen on the last ninth pulse.
	logic last_ack;

	////////////////////////////////////////////////////////////////////////
	// Both lines start released, so the pull-ups hold them high.
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		last_ack = 1'b0;
	end

	// One clock pulse; a stretched low clock is waited out, not overrun.
	// Lines move by non-blocking assignment, so a move that lands on a
	// clock edge never races the device's pin sampler.
	task automatic pulse(output logic s);
		#HALF scl_oe <= 1'b0;
		wait (scl === 1'b1);
		s = sda;
		#HALF scl_oe <= 1'b1;
	endtask

	// Data falls while the clock is high, then the clock follows.
	task automatic start_cond();
		sda_oe <= 1'b1;
		#HALF scl_oe <= 1'b1;
	endtask

	// Eight bits most significant first, then a released ninth bit.
	task automatic send_byte(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			// Data moves a little after the clock fell, never with it.
			#25 sda_oe <= ~b[i];
			pulse(s);
		end
		#25 sda_oe <= 1'b0;
		pulse(s);
		last_ack = ~s;
	endtask

	// Data rises while the clock is high; lines then stay idle.
	task automatic stop_cond();
		#25 sda_oe <= 1'b1;
		#HALF scl_oe <= 1'b0;
		wait (scl === 1'b1);
		#HALF sda_oe <= 1'b0;
		#HALF;
	endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/10ps
// Register accesses over AHB-Lite while a model master drives the wire.
module testbench
	import iar_pkg::*;
;
	logic mclk;
	logic rst_n;
	logic hsel;
	logic hwrite;
	logic hready;
	logic hresp;
	logic bus_irq;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic dut_scl_oe;
	logic dut_sda_oe;
	logic far_scl_oe;
	logic far_sda_oe;
	// Open-drain wires with pull-ups: high unless someone pulls low.
	wire logic scl_w;
	wire logic sda_w;
	logic [31:0] bad_count;
	logic [31:0] checked;
	logic [31:0] irq_cnt;
	// Extension codes in kind order, with expected status bits 5:4.
	localparam logic [47:0] EXT_CODE = 48'h00010204f0f8;
	localparam logic [47:0] EXT_ST = 48'h202020203020;

	assign scl_w = !(dut_scl_oe || far_scl_oe);
	assign sda_w = !(dut_sda_oe || far_sda_oe);

	iar_top #(.HALF_CYC(12'd4)) iar_top_inst (
		.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hresp(hresp),
		.hrdata(hrdata), .bus_clock_line_in(scl_w),
		.bus_clock_line_out(), .bus_clock_line_oe(dut_scl_oe),
		.bus_data_line_in(sda_w), .bus_data_line_out(),
		.bus_data_line_oe(dut_sda_oe), .bus_irq(bus_irq)
	);

	iar_far_master far_inst (
		.scl(scl_w), .sda(sda_w), .scl_oe(far_scl_oe), .sda_oe(far_sda_oe)
	);

	////////////////////////////////////////////////////////////////////////
	// 40 MHz clock.
	always #12.5 mclk = ~mclk;

	// Interrupts are single-cycle pulses, so they are counted, not polled.
	always @(posedge mclk) begin
		if (bus_irq === 1'b1) begin
			irq_cnt <= irq_cnt + 1;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
			bad_count = bad_count + 1;
		end
	endtask

	task automatic test_done();
		if (bad_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// One single word transfer: address phase, then data phase.
	task automatic ahb_go(input logic [4:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {27'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		r = hrdata;
	endtask

	// Bounded wait until the interrupt count reaches a target.
	task automatic wait_irq(input logic [31:0] t);
		for (int k = 0; k < 4000 && irq_cnt < t; k++) @(posedge mclk);
		chk(irq_cnt, t);
	endtask

	// A whole frame from the model; mid says an interrupt must come early.
	task automatic frame(input logic [7:0] a, input logic mid,
		input logic [7:0] st, input logic [7:0] kind,
		input logic [7:0] ctl, input logic ak);
		logic [31:0] n0;
		logic [31:0] d;
		n0 = irq_cnt;
		fork
			begin
				far_inst.start_cond();
				far_inst.send_byte(a);
			end
		join_none
		if (mid) begin
			wait_irq(n0 + 1);
			ahb_go(ADDR_STAT, 1'b0, 32'h0, d);
			chk(d & 32'h30, {24'h0, st});
			ahb_go(ADDR_FLAG, 1'b0, 32'h0, d);
			chk((d >> 1) & 32'h7, {24'h0, kind});
			// Without this write the model would hang on the held clock.
			ahb_go(ADDR_CTRL, 1'b1, {24'h0, ctl}, d);
		end
		wait fork;
		chk(irq_cnt, n0 + {31'h0, mid});
		chk({31'h0, far_inst.last_ack}, {31'h0, ak});
		far_inst.stop_cond();
		wait_irq(n0 + {31'h0, mid} + 1);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		logic [31:0] d;
		mclk = 1'b0;
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		bad_count = 32'h0;
		checked = 32'h0;
		irq_cnt = 32'h0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		// Reset values, including an unmapped word that ignores writes.
		ahb_go(5'h18, 1'b1, 32'hff, d);
		for (int i = 0; i < 7; i++) begin
			ahb_go(5'(i * 4), 1'b0, 32'h0, d);
			chk(d, 32'h0);
		end
		// Every extension kind against a ten-bit-prefix local address.
		ahb_go(ADDR_LSA, 1'b1, 32'hf0, d);
		ahb_go(ADDR_CTRL, 1'b1, 32'h10, d);
		for (int i = 0; i < 6; i++) begin
			frame(EXT_CODE[8 * (5 - i) +: 8], 1'b1, EXT_ST[8 * (5 - i) +: 8],
				8'(i + 1), 8'h12, 1'b0);
		end
		ahb_go(ADDR_LSA, 1'b0, 32'h0, d);
		chk(d, 32'hf0);
		// A matching address, then a foreign one.
		ahb_go(ADDR_LSA, 1'b1, 32'ha4, d);
		frame(8'ha4, 1'b1, 8'h10, 8'h0, 8'h14, 1'b1);
		frame(8'ha6, 1'b0, 8'h0, 8'h0, 8'h0, 1'b0);
		// A start request while another master holds the bus is reserved.
		far_inst.start_cond();
		far_inst.send_byte(8'ha6);
		// With reservation off the same request is refused and flagged.
		ahb_go(ADDR_FLAG, 1'b1, 32'h1, d);
		ahb_go(ADDR_CTRL, 1'b1, 32'h50, d);
		ahb_go(ADDR_FLAG, 1'b0, 32'h0, d);
		chk(d, 32'hc1);
		ahb_go(ADDR_FLAG, 1'b1, 32'h0, d);
		ahb_go(ADDR_CTRL, 1'b1, 32'h50, d);
		repeat (46) @(posedge mclk);
		ahb_go(ADDR_STAT, 1'b0, 32'h0, d);
		chk(d & 32'h80, 32'h0);
		ahb_go(ADDR_SHIFT, 1'b1, 32'h5a, d);
		ahb_go(ADDR_SHIFT, 1'b0, 32'h0, d);
		chk(d, 32'ha6);
		d = irq_cnt;
		far_inst.stop_cond();
		wait_irq(d + 1);
		repeat (46) @(posedge mclk);
		ahb_go(ADDR_STAT, 1'b0, 32'h0, d);
		chk(d & 32'h80, 32'h80);
		chk({31'h0, sda_w}, 32'h0);
		test_done();
	end

	// Watchdog: the whole run needs well under this span.
	initial begin
		#500000;
		bad_count = bad_count + 1;
		test_done();
	end
endmodule
